// file: lcdmac_pkg.sv
package lcdmac_pkg;

  // command codes on the host bus
  localparam logic [7:0] CMD_RMW_START = 8'hE0;
  localparam logic [7:0] CMD_RMW_END   = 8'hEE;
  localparam logic [7:0] CMD_SOFT_RST  = 8'hE2;

  // geometry defaults
  localparam int PAGES      = 4;
  localparam int COLS       = 80;
  localparam int SEGS       = 61;
  localparam int COMS       = 16;
  localparam int COL_W      = 7;
  localparam int PAGE_W     = 2;
  localparam int LINE_W     = 5;
  localparam int MEM_IDX_W  = 9;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 9;

  // reset values
  localparam logic [PAGE_W-1:0] PAGE_RST       = 2'h0;
  localparam logic [PAGE_W-1:0] PAGE_SOFT_RST  = 2'h3;
  localparam logic [LINE_W-1:0] START_SOFT_RST = 5'h00;
  localparam logic [COL_W-1:0]  COL_RST        = 7'h00;
  localparam logic [7:0]        BYTE_RST       = 8'h00;

  // status byte field positions
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_RMW_BIT   = 6;
  localparam int ST_OFF_BIT   = 5;
  localparam int ST_RESET_BIT = 4;

  // scan timing: line time in ns at a 10 ns clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINE_TIME_NS  = 640;
  localparam int LINE_CYCLES   = (LINE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bias level selected on a driver output
  typedef enum logic [2:0] {
    BIAS_SUPPLY,
    BIAS_LEVEL_FIRST,
    BIAS_LEVEL_SECOND,
    BIAS_LEVEL_THIRD,
    BIAS_LEVEL_FOURTH,
    BIAS_LEVEL_FIFTH
  } lcdmac_bias_t;

endpackage : lcdmac_pkg

// file: lcdmac_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module lcdmac_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [WIDTH-1:0] store_next [DEPTH];
  logic [AW-1:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0]      count_reg, count_next;
  logic             push, pop;

  // honest full and empty
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = store_reg[rptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next pointers, count and storage
  always_comb begin
    store_next = store_reg;
    wptr_next  = wptr_reg;
    rptr_next  = rptr_reg;
    count_next = count_reg;
    if (push) begin
      store_next[wptr_reg] = in_data;
      wptr_next = (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // register state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        store_reg[i] <= '0;
      end
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      store_reg <= store_next;
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      count_reg <= count_next;
    end
  end

endmodule : lcdmac_fifo
`default_nettype wire

// file: lcdmac_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcdmac_top import lcdmac_pkg::*; #(
  parameter int SEG_N = SEGS,
  parameter int COM_N = COMS,
  parameter int LINE_N = LINE_CYCLES
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // host bus pins
  input  wire logic              cd,
  input  wire logic              rd_b,
  input  wire logic              wr_b,
  input  wire logic [7:0]        host_data_lines_in,
  output logic      [7:0]        host_data_lines_out,
  output logic                   host_data_lines_oe_b,
  // address and display control
  input  wire logic              addr_load,
  input  wire logic [PAGE_W-1:0] addr_page,
  input  wire logic [COL_W-1:0]  addr_col,
  input  wire logic [LINE_W-1:0] addr_start_line,
  input  wire logic              display_on,
  // status
  output logic                   busy,
  output logic                   rmw_active,
  output logic [PAGE_W-1:0]      page_bits,
  output logic [COL_W-1:0]       column_addr,
  output logic [LINE_W-1:0]      start_line_bits,
  // driver outputs
  output logic                   frame_polarity,
  output lcdmac_bias_t           segment_outputs [SEG_N],
  output lcdmac_bias_t           common_outputs [COM_N]
);
  default clocking @(posedge clock); endclocking // all checks share the core clock
  default disable iff (!rst_b);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [10:0] pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic        cd_s, rd_s, wr_s, rd_prev, wr_prev;
  logic [7:0]  data_s;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_reg   <= 11'h600;
      pin_s2_reg   <= 11'h600;
      pin_prev_reg <= 11'h600;
    end else begin
      pin_s1_reg   <= {rd_b, wr_b, cd, host_data_lines_in};
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  assign rd_s    = pin_s2_reg[10];
  assign wr_s    = pin_s2_reg[9];
  assign cd_s    = pin_s2_reg[8];
  assign data_s  = pin_s2_reg[7:0];
  assign rd_prev = pin_prev_reg[10];
  assign wr_prev = pin_prev_reg[9];

  // access decode
  logic rd_start, rd_end, rd_mem, wr_end, in_ready;
  assign rd_start = rd_prev & ~rd_s & wr_s;
  assign rd_end   = ~rd_prev & rd_s;
  assign rd_mem   = cd_s;
  assign wr_end   = ~wr_prev & wr_s & rd_s;

  //////////////////////////////////////////////////////////////////////////////
  // write queue between host and executor
  logic                  q_valid, q_ready;
  logic [FIFO_WIDTH-1:0] q_data;

  assign q_ready = ~rd_end;
  lcdmac_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_valid  (wr_end),
    .in_ready  (in_ready),
    .in_data   ({cd_s, data_s}),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );
  assign busy = q_valid | ~in_ready;

  //////////////////////////////////////////////////////////////////////////////
  // address, mode and memory state
  logic [7:0]        mem_reg [PAGES*COLS];
  logic [7:0]        mem_next [PAGES*COLS];
  logic [PAGE_W-1:0] page_reg, page_next;
  logic [COL_W-1:0]  col_reg, col_next, col_save_reg, col_save_next, col_inc;
  logic [LINE_W-1:0] start_reg, start_next;
  logic              rmw_reg, rmw_next;
  logic [7:0]        latch_reg, latch_next;
  logic [MEM_IDX_W-1:0] mem_idx;
  logic              q_pop, q_is_data;

  assign mem_idx   = MEM_IDX_W'(32'(page_reg) * COLS + 32'(col_reg));
  assign col_inc   = (col_reg == COL_W'(COLS - 1)) ? COL_RST : col_reg + 1'b1;
  assign q_pop     = q_valid & q_ready;
  assign q_is_data = q_data[8];

  // executor, host reads and address loads
  always_comb begin
    mem_next      = mem_reg;
    page_next     = page_reg;
    col_next      = col_reg;
    col_save_next = col_save_reg;
    start_next    = start_reg;
    rmw_next      = rmw_reg;
    latch_next    = latch_reg;
    if (addr_load) begin
      page_next  = addr_page;
      start_next = addr_start_line;
      if (!rmw_reg) begin
        col_next = addr_col;
      end
    end
    if (rd_end && rd_mem) begin
      latch_next = mem_reg[mem_idx];
      if (!rmw_reg) begin
        col_next = col_inc;
      end
    end else if (q_pop && q_is_data) begin
      mem_next[mem_idx] = q_data[7:0];
      col_next = col_inc;
    end else if (q_pop) begin
      if (q_data[7:0] == CMD_RMW_START) begin
        rmw_next      = 1'b1;
        col_save_next = col_reg;
      end else if (q_data[7:0] == CMD_RMW_END) begin
        if (rmw_reg) begin
          col_next = col_save_reg;
        end
        rmw_next = 1'b0;
      end else if (q_data[7:0] == CMD_SOFT_RST) begin
        start_next = START_SOFT_RST;
        page_next  = PAGE_SOFT_RST;
      end
    end
  end

  // register address, mode and memory
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg      <= '{default: BYTE_RST};
      page_reg     <= PAGE_RST;
      col_reg      <= COL_RST;
      col_save_reg <= COL_RST;
      start_reg    <= START_SOFT_RST;
      rmw_reg      <= 1'b0;
      latch_reg    <= BYTE_RST;
    end else begin
      mem_reg      <= mem_next;
      page_reg     <= page_next;
      col_reg      <= col_next;
      col_save_reg <= col_save_next;
      start_reg    <= start_next;
      rmw_reg      <= rmw_next;
      latch_reg    <= latch_next;
    end
  end

  assign rmw_active      = rmw_reg;
  assign page_bits       = page_reg;
  assign column_addr     = col_reg;
  assign start_line_bits = start_reg;

  //////////////////////////////////////////////////////////////////////////////
  // host read data
  logic [7:0] dout_reg, dout_next, status_byte;
  logic       oe_b_reg, oe_b_next;

  assign status_byte = (8'(busy) << ST_BUSY_BIT) | (8'(rmw_reg) << ST_RMW_BIT)
                     | (8'(!display_on) << ST_OFF_BIT);

  // drive latch or status while the read strobe is low
  always_comb begin
    dout_next = dout_reg;
    oe_b_next = oe_b_reg;
    if (rd_start) begin
      dout_next = rd_mem ? latch_reg : status_byte;
      oe_b_next = 1'b0;
    end else if (rd_s) begin
      oe_b_next = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dout_reg <= BYTE_RST;
      oe_b_reg <= 1'b1;
    end else begin
      dout_reg <= dout_next;
      oe_b_reg <= oe_b_next;
    end
  end

  assign host_data_lines_out  = dout_reg;
  assign host_data_lines_oe_b = oe_b_reg;

  //////////////////////////////////////////////////////////////////////////////
  // scan timing: line divider, common counter, frame
  logic [15:0]           div_reg, div_next;
  logic [$clog2(COM_N)-1:0] com_cnt_reg, com_cnt_next;
  logic                  frame_reg, frame_next, line_tick;

  assign line_tick = (div_reg == 16'(LINE_N - 1));

  always_comb begin
    div_next     = line_tick ? 16'h0000 : div_reg + 16'h0001;
    com_cnt_next = com_cnt_reg;
    frame_next   = frame_reg;
    if (line_tick) begin
      if (com_cnt_reg == ($clog2(COM_N))'(COM_N - 1)) begin
        com_cnt_next = '0;
        frame_next   = ~frame_reg;
      end else begin
        com_cnt_next = com_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_reg     <= 16'h0000;
      com_cnt_reg <= '0;
      frame_reg   <= 1'b0;
    end else begin
      div_reg     <= div_next;
      com_cnt_reg <= com_cnt_next;
      frame_reg   <= frame_next;
    end
  end

  assign frame_polarity = frame_reg;

  //////////////////////////////////////////////////////////////////////////////
  // driver level selection
  lcdmac_bias_t      seg_reg [SEG_N];
  lcdmac_bias_t      seg_next [SEG_N];
  lcdmac_bias_t      com_reg [COM_N];
  lcdmac_bias_t      com_next [COM_N];
  logic [LINE_W-1:0] scan_row;
  logic              pix;

  assign scan_row = start_reg + LINE_W'(com_cnt_reg);

  always_comb begin
    pix = 1'b0;
    for (int s = 0; s < SEG_N; s++) begin
      pix = mem_reg[MEM_IDX_W'(32'(scan_row[4:3]) * COLS + s)][scan_row[2:0]];
      if (!display_on) begin
        seg_next[s] = frame_reg ? BIAS_LEVEL_SECOND : BIAS_LEVEL_THIRD;
      end else if (!frame_reg) begin
        seg_next[s] = pix ? BIAS_LEVEL_FIFTH : BIAS_LEVEL_THIRD;
      end else begin
        seg_next[s] = pix ? BIAS_SUPPLY : BIAS_LEVEL_SECOND;
      end
    end
    for (int c = 0; c < COM_N; c++) begin
      if (!display_on) begin
        com_next[c] = com_reg[c];
      end else if (!frame_reg) begin
        com_next[c] = (c == int'(com_cnt_reg)) ? BIAS_SUPPLY : BIAS_LEVEL_FOURTH;
      end else begin
        com_next[c] = (c == int'(com_cnt_reg)) ? BIAS_LEVEL_FIFTH : BIAS_LEVEL_FIRST;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seg_reg <= '{default: BIAS_SUPPLY};
      com_reg <= '{default: BIAS_SUPPLY};
    end else begin
      seg_reg <= seg_next;
      com_reg <= com_next;
    end
  end

  assign segment_outputs = seg_reg;
  assign common_outputs  = com_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_read_old_latch;
    rd_start && rd_mem |=> host_data_lines_out == $past(latch_reg) && !host_data_lines_oe_b;
  endproperty
  a_read_old_latch: assert property (p_read_old_latch) else $error("read not old latch");
  property p_latch_load;
    rd_end && rd_mem |=> latch_reg == $past(mem_reg[mem_idx]);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");
  property p_read_inc;
    rd_end && rd_mem && !rmw_reg && !addr_load |=> col_reg == $past(col_inc);
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("read did not increment");
  property p_rmw_read_hold;
    rd_end && rd_mem && rmw_reg |=> $stable(col_reg);
  endproperty
  a_rmw_read_hold: assert property (p_rmw_read_hold) else $error("rmw read moved column");
  property p_write_store;
    q_pop && q_is_data |=> mem_reg[$past(mem_idx)] == $past(q_data[7:0])
      && col_reg == $past(col_inc);
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored");
  property p_rmw_enter;
    q_pop && !q_is_data && q_data[7:0] == CMD_RMW_START
      |=> rmw_reg && col_save_reg == $past(col_reg);
  endproperty
  a_rmw_enter: assert property (p_rmw_enter) else $error("rmw entry wrong");
  property p_rmw_end;
    q_pop && !q_is_data && q_data[7:0] == CMD_RMW_END && rmw_reg && !rd_end
      |=> !rmw_reg && col_reg == $past(col_save_reg);
  endproperty
  a_rmw_end: assert property (p_rmw_end) else $error("end did not restore");
  property p_soft_reset;
    q_pop && !q_is_data && q_data[7:0] == CMD_SOFT_RST && !addr_load
      |=> start_reg == START_SOFT_RST && page_reg == PAGE_SOFT_RST && $stable(col_reg);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");
  property p_seg_level;
    display_on && !frame_reg && !line_tick |=> seg_reg[0] inside {BIAS_LEVEL_THIRD, BIAS_LEVEL_FIFTH};
  endproperty
  a_seg_level: assert property (p_seg_level) else $error("segment level wrong");
  property p_busy_queue;
    wr_end |=> busy [*1] ##0 q_valid;
  endproperty
  a_busy_queue: assert property (p_busy_queue) else $error("busy not shown");

  c_rmw_cycle: cover property (rmw_reg ##[1:200] !rmw_reg);
  c_mem_read:  cover property (rd_end && rd_mem);
  c_full:      cover property (!in_ready);
  c_frame:     cover property ($rose(frame_reg));

endmodule : lcdmac_top
`default_nettype wire

// file: lcdmac_host.sv
`timescale 1ns/1ps
`default_nettype none
module lcdmac_host (
  // clock and device status
  input  wire logic       clock,
  input  wire logic       busy,
  // device data pins
  input  wire logic [7:0] host_data_lines_out,
  input  wire logic       host_data_lines_oe_b,
  // host bus pins
  output logic            cd,
  output logic            rd_b,
  output logic            wr_b,
  output logic      [7:0] host_data_lines_in
);
  logic [7:0] drv_reg;

  ////////////////////////////////////////////////////////////
  // resolved data bus: the device wins while it drives
  assign host_data_lines_in = host_data_lines_oe_b ? drv_reg : host_data_lines_out;

  // idle bus, a released line shows a changing pattern
  initial begin
    cd      = 1'b1;
    rd_b    = 1'b1;
    wr_b    = 1'b1;
    drv_reg = 8'hA5;
  end

  // one strobe cycle; caller enters at a rising edge
  task automatic xfer(input logic c, input logic is_rd, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
    cd      <= c;
    drv_reg <= d;
    if (is_rd)
      rd_b <= 1'b0;
    else
      wr_b <= 1'b0;
    repeat (6) @(posedge clock);
    q = host_data_lines_in;
    rd_b <= 1'b1;
    wr_b <= 1'b1;
    // data and select held past the synchronised strobe rise
    repeat (4) @(posedge clock);
    drv_reg <= ~d;
    repeat (6) @(posedge clock);
  endtask : xfer
endmodule : lcdmac_host
`default_nettype wire

// file: lcd_memory_access_commands_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_memory_access_commands_tb;
  import lcdmac_pkg::*;
  localparam int LINE_T = 8;
  logic              clock, rst_b, cd, rd_b, wr_b, oe_b, busy, rmw_active;
  logic              addr_load, display_on, frame_polarity;
  logic [7:0]        din, dout;
  logic [PAGE_W-1:0] addr_page, page_bits;
  logic [COL_W-1:0]  addr_col, column_addr;
  logic [LINE_W-1:0] addr_start_line, start_line_bits;
  lcdmac_bias_t      segs [SEGS];
  lcdmac_bias_t      coms [COMS];
  logic [7:0]        mem_model [int];
  int                miscompares, compares;

  ////////////////////////////////////////////////////////////
  // clock, watchdog and instances
  always #5 clock = ~clock;

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results();
  end

  lcdmac_top #(.SEG_N(SEGS), .COM_N(COMS), .LINE_N(LINE_T)) DUT (
    .clock(clock), .rst_b(rst_b), .cd(cd), .rd_b(rd_b), .wr_b(wr_b),
    .host_data_lines_in(din), .host_data_lines_out(dout), .host_data_lines_oe_b(oe_b),
    .addr_load(addr_load), .addr_page(addr_page), .addr_col(addr_col),
    .addr_start_line(addr_start_line), .display_on(display_on), .busy(busy),
    .rmw_active(rmw_active), .page_bits(page_bits), .column_addr(column_addr),
    .start_line_bits(start_line_bits), .frame_polarity(frame_polarity),
    .segment_outputs(segs), .common_outputs(coms));

  lcdmac_host HOST (
    .clock(clock), .busy(busy), .host_data_lines_out(dout), .host_data_lines_oe_b(oe_b),
    .cd(cd), .rd_b(rd_b), .wr_b(wr_b), .host_data_lines_in(din));

  ////////////////////////////////////////////////////////////
  // expectation helpers and shared tasks
  function automatic logic [COL_W-1:0] next_col(input int c, input int n);
    return COL_W'((c + n) % COLS);
  endfunction : next_col

  function automatic int idx(input int p, input int c);
    return p * COLS + c;
  endfunction : idx

  function automatic bit seg_ok(input logic f, input logic on, input logic px,
                                input lcdmac_bias_t v);
    if (!on)
      return v === (f ? BIAS_LEVEL_SECOND : BIAS_LEVEL_THIRD);
    return f ? (v === (px ? BIAS_SUPPLY : BIAS_LEVEL_SECOND))
             : (v === (px ? BIAS_LEVEL_FIFTH : BIAS_LEVEL_THIRD));
  endfunction : seg_ok

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic set_addr(input logic [1:0] p, input logic [6:0] c, input logic [4:0] s);
    addr_page       <= p;
    addr_col        <= c;
    addr_start_line <= s;
    addr_load       <= 1'b1;
    @(posedge clock);
    addr_load <= 1'b0;
    @(posedge clock);
  endtask : set_addr

  // waits for a frame flip, then checks every driver output
  task automatic check_bias();
    lcdmac_bias_t hold [COMS];
    int           act;
    logic         f, pix;
    @(frame_polarity);
    repeat (3) @(negedge clock);
    f    = frame_polarity;
    act  = 0;
    hold = coms;
    // start line is 0 and the scan sits on row 0, bit 0 of page 0
    foreach (segs[i]) begin
      pix = mem_model.exists(idx(0, i)) ? mem_model[idx(0, i)][0] : 1'b0;
      check(seg_ok(f, display_on, pix, segs[i]), 1, "segment level");
    end
    if (display_on) begin
      foreach (coms[i]) begin
        check(f ? (coms[i] === BIAS_LEVEL_FIRST || coms[i] === BIAS_LEVEL_FIFTH)
                : (coms[i] === BIAS_LEVEL_FOURTH || coms[i] === BIAS_SUPPLY), 1, "common");
        act += (coms[i] === (f ? BIAS_LEVEL_FIFTH : BIAS_SUPPLY));
      end
      check(act, 1, "active rows");
    end else begin
      repeat (20) @(negedge clock);
      foreach (coms[i]) check(coms[i], hold[i], "common hold");
    end
    @(posedge clock);
  endtask : check_bias

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [1:0] p;
    logic [6:0] c;
    logic [7:0] b, q;
    void'($urandom(32));
    clock = 1'b0; rst_b = 1'b0; addr_load = 1'b0; display_on = 1'b1;
    addr_page = 2'h0; addr_col = 7'h00; addr_start_line = 5'h00;
    repeat (10) @(posedge clock);
    foreach (segs[i]) check(segs[i], BIAS_SUPPLY, "segment in reset");
    foreach (coms[i]) check(coms[i], BIAS_SUPPLY, "common in reset");
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    // writes then reads, the first pass across the column wrap
    for (int pass = 0; pass < 2; pass++) begin
      p = 2'($urandom_range(3));
      c = (pass == 0) ? 7'h4E : 7'($urandom_range(COLS - 1));
      set_addr(p, c, 5'h00);
      for (int i = 0; i < 3; i++) begin
        b = 8'($urandom);
        mem_model[idx(p, next_col(c, i))] = b;
        HOST.xfer(1'b1, 1'b0, b, q);
        check(column_addr, next_col(c, i + 1), "column after write");
      end
      set_addr(p, c, 5'h00);
      HOST.xfer(1'b1, 1'b1, 8'h00, q);
      check(column_addr, next_col(c, 1), "column after dummy");
      for (int i = 0; i < 2; i++) begin
        HOST.xfer(1'b1, 1'b1, 8'h00, q);
        check(q, mem_model[idx(p, next_col(c, i))], "read data");
        check(column_addr, next_col(c, i + 2), "column after read");
      end
    end
    // read-modify-write round on the first column written in the second pass
    set_addr(p, c, 5'h00);
    HOST.xfer(1'b0, 1'b0, CMD_RMW_START, q);
    check(rmw_active, 1, "rmw entered");
    HOST.xfer(1'b1, 1'b1, 8'h00, q);
    HOST.xfer(1'b1, 1'b1, 8'h00, q);
    check(q, mem_model[idx(p, c)], "rmw read");
    check(column_addr, c, "rmw column held");
    b = 8'($urandom);
    mem_model[idx(p, c)] = b;
    HOST.xfer(1'b1, 1'b0, b, q);
    check(column_addr, next_col(c, 1), "rmw write column");
    set_addr(~p, next_col(c, 9), 5'h0A);
    check(page_bits, p ^ 2'h3, "rmw page load");
    check(column_addr, next_col(c, 1), "rmw column locked");
    HOST.xfer(1'b0, 1'b0, CMD_RMW_END, q);
    check(column_addr, c, "column restored");
    check(rmw_active, 0, "rmw left");
    set_addr(p, next_col(c, 5), 5'h00);
    HOST.xfer(1'b0, 1'b0, CMD_RMW_END, q);
    check(column_addr, next_col(c, 5), "stray end");
    // software reset keeps memory and column
    set_addr(2'h1, c, 5'h15);
    HOST.xfer(1'b0, 1'b0, CMD_SOFT_RST, q);
    check(start_line_bits, START_SOFT_RST, "start line");
    check(page_bits, PAGE_SOFT_RST, "page");
    check(column_addr, c, "column kept");
    set_addr(p, c, 5'h00);
    HOST.xfer(1'b1, 1'b1, 8'h00, q);
    HOST.xfer(1'b1, 1'b1, 8'h00, q);
    check(q, mem_model[idx(p, c)], "memory kept");
    // writes in a row through the write queue into page 0, read back in order
    set_addr(2'h0, 7'h00, 5'h00);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      b = (i == 0) ? 8'hFF : 8'($urandom);
      mem_model[idx(0, i)] = b;
      HOST.xfer(1'b1, 1'b0, b, q);
      check(busy, 0, "queue drained");
    end
    set_addr(2'h0, 7'h00, 5'h00);
    HOST.xfer(1'b1, 1'b1, 8'h00, q);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      HOST.xfer(1'b1, 1'b1, 8'h00, q);
      check(q, mem_model[idx(0, i)], "queue order");
    end
    // driver outputs, display on then off
    check_bias();
    check_bias();
    display_on <= 1'b0;
    check_bias();
    check_bias();
    // status read: idle, not in rmw, display off
    HOST.xfer(1'b0, 1'b1, 8'h00, q);
    check(q, 8'h20, "status byte");
    results();
  end
endmodule : lcd_memory_access_commands_tb
`default_nettype wire
